// *** sim/ocs_board_model.sv ***
// ocs_board_model.sv: option board and host master seen from the supervisor
// assumes bench commands synchronous to clk_sys
module ocs_board_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // commands from the bench
  input wire logic send_msgs,
  input wire logic [7:0] gap,
  input wire logic inject_fault,
  // link events toward the supervisor
  output logic host_msg_valid,
  output logic link_fault
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] cnt;

  // ==========================================
  // host master traffic
  // one pulse every gap+1 cycles; a large gap models a slow host
  always_ff @(posedge clk_sys) begin
    if (rst || !send_msgs) begin
      cnt <= 8'h00;
      host_msg_valid <= 1'b0;
    end else begin
      host_msg_valid <= (cnt == gap);
      cnt <= (cnt == gap) ? 8'h00 : cnt + 8'h01;
    end
  end

  // board transfer error, only when the bench commands it
  always_ff @(posedge clk_sys) begin
    link_fault <= rst ? 1'b0 : inject_fault;
  end
endmodule

// *** sim/ocs_top_tb.sv ***
// ocs_top_tb.sv: self-checking bench of the option comm supervisor
// assumes ocs_top with a short watchdog tick and the board model beside it
`include "ocs_cfg.svh"

module ocs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, trip_req, decel_stop_req, coast_stop_req;
  logic [31:0] prdata;
  logic drive_running = 1'b0;
  logic option_fitted = 1'b1;
  logic send_msgs = 1'b0;
  logic inject_fault = 1'b0;
  logic host_msg_valid, link_fault;
  logic [7:0] station_address;
  logic [159:0] flex_write_map, flex_read_map;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;

  // ==========================================
  // clock, design and far side
  always #4 clk_sys = ~clk_sys;

  ocs_top #(.TICK_CYCLES(4)) i_ocs_top (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .drive_running(drive_running), .option_fitted(option_fitted),
    .host_msg_valid(host_msg_valid), .link_fault(link_fault), .trip_req(trip_req),
    .decel_stop_req(decel_stop_req), .coast_stop_req(coast_stop_req),
    .station_address(station_address), .flex_write_map(flex_write_map),
    .flex_read_map(flex_read_map));

  ocs_board_model i_ocs_board_model (
    .clk_sys(clk_sys), .rst(rst), .send_msgs(send_msgs), .gap(8'h02),
    .inject_fault(inject_fault), .host_msg_valid(host_msg_valid),
    .link_fault(link_fault));

  // ==========================================
  // shared tasks
  task automatic conclude();
    if (miscompares == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // apb cycle; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic e);
    logic [31:0] r;
    logic g;
    apb(1'b1, a, d, r, g);
    chk(g, e);
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] x, input logic e);
    logic [31:0] r;
    logic g;
    apb(1'b0, a, 32'h0, r, g);
    chk(r, x);
    chk(g, e);
  endtask

  // ==========================================
  // scenarios
  // every setting at its limit, one above it refused and value kept
  task automatic t_limits();
    logic [7:0] ad [6] = '{`OCS_A_REACT, `OCS_A_PERIOD, `OCS_A_ACTION,
                           `OCS_A_STATION, `OCS_A_CLRMODE, `OCS_A_MAPSEL};
    logic [15:0] mx [6] = '{16'(`OCS_MAX_REACT), `OCS_MAX_PERIOD,
                            16'(`OCS_MAX_ACTION), 16'(`OCS_MAX_STATION),
                            16'(`OCS_MAX_CLRMODE), 16'(`OCS_MAX_MAPSEL)};
    for (int i = 0; i < 6; i++) begin
      rreg(ad[i], 32'h0, 1'b0);
      wreg(ad[i], {16'h0, mx[i]}, 1'b0);
      wreg(ad[i], {16'h0, mx[i]} + 32'h1, 1'b1);
      rreg(ad[i], {16'h0, mx[i]}, 1'b0);
    end
    chk(station_address, 32'h7d);
    rreg(8'hfc, 32'h0, 1'b1);
    wreg(8'hfc, 32'h1, 1'b1);
  endtask

  // first and last write slots and one middle read slot, upper half dropped
  task automatic t_slots();
    wreg(`OCS_A_WSLOT, 32'hffffabcd, 1'b0);
    wreg(`OCS_A_WSLOT + 8'h24, 32'h0000ffff, 1'b0);
    wreg(`OCS_A_RSLOT + 8'h14, 32'h00001234, 1'b0);
    rreg(`OCS_A_WSLOT, 32'h0000abcd, 1'b0);
    rreg(`OCS_A_RSLOT + 8'h14, 32'h00001234, 1'b0);
    chk(flex_write_map[15:0], 32'habcd);
    chk(flex_write_map[159:144], 32'hffff);
    chk(flex_read_map[95:80], 32'h1234);
  endtask

  // link fault under both reactions; trip exactly one edge after the pulse
  task automatic t_fault(input logic react);
    wreg(`OCS_A_REACT, {31'h0, react}, 1'b0);
    @(posedge clk_sys);
    inject_fault <= 1'b1;
    @(posedge clk_sys);
    inject_fault <= 1'b0;
    #1;
    chk(trip_req, 32'h0);
    @(posedge clk_sys);
    #1;
    chk(trip_req, {31'h0, ~react});
    rreg(`OCS_A_STATUS, {29'h1, 2'b00, ~react}, 1'b0);
    rreg(`OCS_A_FAULTS, 32'h1, 1'b0);
    wreg(`OCS_A_CTRL, 32'h3, 1'b0);
    #1;
    chk(trip_req, 32'h0);
  endtask

  // silence while running applies the selected action
  task automatic t_action(input logic [7:0] act);
    int n;
    logic [2:0] x;
    x = (act == 8'h00) ? 3'b001 : (act == 8'h03) ? 3'b100 :
        (act == 8'h02) ? 3'b000 : 3'b010;
    wreg(`OCS_A_ACTION, {24'h0, act}, 1'b0);
    wreg(`OCS_A_PERIOD, 32'h2, 1'b0);
    @(posedge clk_sys);
    drive_running <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      #1;
    end while ({coast_stop_req, decel_stop_req, trip_req} === 3'b000 && n < 16);
    chk({coast_stop_req, decel_stop_req, trip_req}, x);
    if (x != 3'b000) chk(n >= 7 && n <= 11, 32'h1);
    rreg(`OCS_A_STATUS, {28'h1, 1'b0, x}, 1'b0);
    @(posedge clk_sys);
    drive_running <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk({coast_stop_req, decel_stop_req, trip_req}, act <= 8'h01);
    rreg(`OCS_A_ELAPSED, 32'h0, 1'b0);
    wreg(`OCS_A_CTRL, 32'h3, 1'b0);
  endtask

  // steady host traffic keeps the watchdog quiet until it stops
  task automatic t_traffic();
    send_msgs <= 1'b1;
    wreg(`OCS_A_ACTION, 32'h3, 1'b0);
    @(posedge clk_sys);
    drive_running <= 1'b1;
    repeat (40) @(posedge clk_sys);
    send_msgs <= 1'b0;
    option_fitted <= 1'b0;
    #1;
    chk(coast_stop_req, 32'h0);
    // no option fitted, then period zero: both keep the watchdog off
    repeat (16) @(posedge clk_sys);
    option_fitted <= 1'b1;
    wreg(`OCS_A_PERIOD, 32'h0, 1'b0);
    repeat (16) @(posedge clk_sys);
    #1;
    chk(coast_stop_req, 32'h0);
    wreg(`OCS_A_PERIOD, 32'h2, 1'b0);
    repeat (16) @(posedge clk_sys);
    drive_running <= 1'b0;
    #1;
    chk(coast_stop_req, 32'h1);
    wreg(`OCS_A_CTRL, 32'h3, 1'b0);
  endtask

  // ==========================================
  // main sequence and hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    chk({coast_stop_req, decel_stop_req, trip_req}, 32'h0);
    t_limits();
    t_slots();
    t_fault(1'b1);
    t_fault(1'b0);
    for (int a = 0; a < 5; a++) t_action(a[7:0]);
    t_traffic();
    conclude();
  end
endmodule

// *** src/ocs_cfg.svh ***
// ocs_cfg.svh: offsets, limits, reset values and timing counts
// assumes inclusion by the ocs design files and the bench
`ifndef OCS_CFG_SVH
`define OCS_CFG_SVH

// register byte offsets
`define OCS_A_REACT 8'h00
`define OCS_A_PERIOD 8'h04
`define OCS_A_ACTION 8'h08
`define OCS_A_STATION 8'h0c
`define OCS_A_CLRMODE 8'h10
`define OCS_A_MAPSEL 8'h14
`define OCS_A_STATUS 8'h18
`define OCS_A_CTRL 8'h1c
`define OCS_A_ELAPSED 8'h20
`define OCS_A_FAULTS 8'h24
`define OCS_A_WSLOT 8'h40
`define OCS_A_RSLOT 8'h80
`define OCS_NSLOT 10

// reset values
`define OCS_R_REACT 8'h00
`define OCS_R_PERIOD 16'h0000
`define OCS_R_ACTION 8'h00
`define OCS_R_STATION 8'h00
`define OCS_R_MODE 8'h00
`define OCS_R_SLOT 16'h0000

// accepted maxima
`define OCS_MAX_REACT 8'h01
`define OCS_MAX_PERIOD 16'h270f
`define OCS_MAX_ACTION 8'h04
`define OCS_MAX_STATION 8'h7d
`define OCS_MAX_CLRMODE 8'h01
`define OCS_MAX_MAPSEL 8'h02

// reaction and timeout action codes
`define OCS_REACT_TRIP 8'h00
`define OCS_ACT_TRIP 8'h00
`define OCS_ACT_DECTRIP 8'h01
`define OCS_ACT_IGNORE 8'h02
`define OCS_ACT_COAST 8'h03
`define OCS_ACT_DECEL 8'h04

// status and control bit positions
`define OCS_ST_TRIP 0
`define OCS_ST_DECEL 1
`define OCS_ST_COAST 2
`define OCS_ST_LINK 3
`define OCS_ST_TMO 4
`define OCS_CT_CLRTRIP 0
`define OCS_CT_CLRFLAG 1

// watchdog unit 0.01 s, clock 8 ns
`define OCS_TICK_NS 10000000
`define OCS_CLK_NS 8
`define OCS_TICK_CYCLES ((`OCS_TICK_NS + `OCS_CLK_NS - 1) / `OCS_CLK_NS)

`endif

// *** src/ocs_pkg.sv ***
// ocs_pkg.sv: types of the option communication supervisor
// assumes nothing beyond a SystemVerilog compiler
package ocs_pkg;

  // reaction state of the supervisor
  typedef enum logic [2:0] {
    st_normal,
    st_decel_trip,
    st_decel,
    st_coast,
    st_tripped
  } ocs_state_t;

  typedef logic [15:0] ocs_slot_t;

endpackage

// *** src/ocs_top.sv ***
// ocs_top.sv: option board communication supervisor, APB slave
// assumes zero-wait APB master and inputs synchronous to clk_sys
`include "ocs_cfg.svh"

module ocs_top
  import ocs_pkg::*;
#(
  parameter int TICK_CYCLES = `OCS_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // drive state
  input wire logic drive_running,
  input wire logic option_fitted,
  // option board link events
  input wire logic host_msg_valid,
  input wire logic link_fault,
  // reaction requests to the drive
  output logic trip_req,
  output logic decel_stop_req,
  output logic coast_stop_req,
  // fieldbus configuration to the option board
  output logic [7:0] station_address,
  output logic [16*`OCS_NSLOT-1:0] flex_write_map,
  output logic [16*`OCS_NSLOT-1:0] flex_read_map
);

  generate
    if (TICK_CYCLES < 1) begin : g_bad
      $error("ocs_top: TICK_CYCLES must be positive");
    end
  endgenerate

  // ==========================================================
  // slot decode: {hit, index} for a bank of word slots
  function automatic logic [4:0] slot_dec(
    input logic [7:0] a,
    input logic [7:0] base
  );
    logic [7:0] off;
    off = a - base;
    slot_dec = {(a >= base) && (off < 8'(4 * `OCS_NSLOT)) &&
                (off[1:0] == 2'b00), off[5:2]};
  endfunction

  // ==========================================================
  // registers
  logic [7:0] fault_reaction;
  logic [15:0] watchdog_period;
  logic [7:0] timeout_action;
  logic [7:0] clear_mode;
  logic [7:0] map_select;
  ocs_slot_t flex_wr [`OCS_NSLOT];
  ocs_slot_t flex_rd [`OCS_NSLOT];
  logic link_seen;
  logic tmo_seen;
  logic [7:0] fault_count;
  ocs_state_t state;
  ocs_state_t next_state;
  logic tmo;
  logic [15:0] elapsed;

  // ==========================================================
  // apb decode
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire [4:0] wsd = slot_dec(paddr, `OCS_A_WSLOT);
  wire [4:0] rsd = slot_dec(paddr, `OCS_A_RSLOT);
  wire w_hit = wsd[4];
  wire r_hit = rsd[4];
  wire [3:0] w_idx = wsd[3:0];
  wire [3:0] r_idx = rsd[3:0];
  wire is_react = (paddr == `OCS_A_REACT);
  wire is_period = (paddr == `OCS_A_PERIOD);
  wire is_action = (paddr == `OCS_A_ACTION);
  wire is_station = (paddr == `OCS_A_STATION);
  wire is_clrmode = (paddr == `OCS_A_CLRMODE);
  wire is_mapsel = (paddr == `OCS_A_MAPSEL);
  wire is_status = (paddr == `OCS_A_STATUS);
  wire is_ctrl = (paddr == `OCS_A_CTRL);
  wire is_elapsed = (paddr == `OCS_A_ELAPSED);
  wire is_faults = (paddr == `OCS_A_FAULTS);

  wire addr_ok = is_react || is_period || is_action || is_station ||
                 is_clrmode || is_mapsel || is_status || is_ctrl ||
                 is_elapsed || is_faults || w_hit || r_hit;

  // out-of-range values are refused so settings stay legal
  wire val_ok =
    is_react ? (pwdata <= 32'(`OCS_MAX_REACT)) :
    is_period ? (pwdata <= 32'(`OCS_MAX_PERIOD)) :
    is_action ? (pwdata <= 32'(`OCS_MAX_ACTION)) :
    is_station ? (pwdata <= 32'(`OCS_MAX_STATION)) :
    is_clrmode ? (pwdata <= 32'(`OCS_MAX_CLRMODE)) :
    is_mapsel ? (pwdata <= 32'(`OCS_MAX_MAPSEL)) :
    1'b1;

  wire bus_err = !addr_ok || (pwrite && !val_ok);
  wire wr_ok = access && pwrite && !bus_err;

  // zero-wait slave: every access completes in one access cycle
  assign pready = access;
  assign pslverr = access && bus_err;

  // ==========================================================
  // read selection
  wire [31:0] status_word = 32'({tmo_seen, link_seen, coast_stop_req,
                                 decel_stop_req, trip_req});

  wire [31:0] rd_word =
    is_react ? 32'(fault_reaction) :
    is_period ? 32'(watchdog_period) :
    is_action ? 32'(timeout_action) :
    is_station ? 32'(station_address) :
    is_clrmode ? 32'(clear_mode) :
    is_mapsel ? 32'(map_select) :
    is_status ? status_word :
    is_elapsed ? 32'(elapsed) :
    is_faults ? 32'(fault_count) :
    w_hit ? 32'(flex_wr[w_idx]) :
    r_hit ? 32'(flex_rd[r_idx]) :
    32'h0;

  // read data captured in setup, stable through the access cycle
  always_ff @(posedge clk_sys) begin
    if (rst) prdata <= 32'h0;
    else if (setup && !pwrite) prdata <= rd_word;
  end

  // ==========================================================
  // settings registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_reaction <= `OCS_R_REACT;
      watchdog_period <= `OCS_R_PERIOD;
      timeout_action <= `OCS_R_ACTION;
      station_address <= `OCS_R_STATION;
      clear_mode <= `OCS_R_MODE;
      map_select <= `OCS_R_MODE;
    end else if (wr_ok) begin
      if (is_react) fault_reaction <= pwdata[7:0];
      if (is_period) watchdog_period <= pwdata[15:0];
      if (is_action) timeout_action <= pwdata[7:0];
      if (is_station) station_address <= pwdata[7:0];
      if (is_clrmode) clear_mode <= pwdata[7:0];
      if (is_mapsel) map_select <= pwdata[7:0];
    end
  end

  // command slot banks; upper data bits are dropped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < `OCS_NSLOT; i++) begin
        flex_wr[i] <= `OCS_R_SLOT;
        flex_rd[i] <= `OCS_R_SLOT;
      end
    end else if (wr_ok) begin
      if (w_hit) flex_wr[w_idx] <= pwdata[15:0];
      if (r_hit) flex_rd[r_idx] <= pwdata[15:0];
    end
  end

  // slot banks face the option board as flat words
  genvar g;
  generate
    for (g = 0; g < `OCS_NSLOT; g++) begin : g_map
      assign flex_write_map[16*g +: 16] = flex_wr[g];
      assign flex_read_map[16*g +: 16] = flex_rd[g];
    end
  endgenerate

  // ==========================================================
  // watchdog: runs only while driving with an option fitted
  wire wd_enable = drive_running && option_fitted;

  ocs_wdog #(
    .TICK_CYCLES(TICK_CYCLES),
    .PERIOD_W(16)
  ) u_wdog (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(wd_enable),
    .restart(host_msg_valid),
    .period(watchdog_period),
    .timeout(tmo),
    .elapsed(elapsed)
  );

  // ==========================================================
  // event decode
  wire ctrl_wr = wr_ok && is_ctrl;
  wire clr_trip = ctrl_wr && pwdata[`OCS_CT_CLRTRIP];
  wire clr_flag = ctrl_wr && pwdata[`OCS_CT_CLRFLAG];
  wire fault_trip = link_fault && (fault_reaction == `OCS_REACT_TRIP);
  wire tmo_trip = tmo && (timeout_action == `OCS_ACT_TRIP);
  wire tmo_dectrip = tmo && (timeout_action == `OCS_ACT_DECTRIP);
  wire tmo_coast = tmo && (timeout_action == `OCS_ACT_COAST);
  wire tmo_decel = tmo && (timeout_action == `OCS_ACT_DECEL);
  wire trip_evt = fault_trip || tmo_trip;

  // ==========================================================
  // reaction state machine
  // a fault under continued operation leaves the state alone
  always_comb begin
    next_state = state;
    case (state)
      st_tripped: begin
        // a new trip event in the clearing cycle wins
        if (clr_trip && !trip_evt) next_state = st_normal;
      end
      st_normal, st_decel, st_coast, st_decel_trip: begin
        if (trip_evt) begin
          next_state = st_tripped;
        end else if (state == st_decel_trip) begin
          if (!drive_running) next_state = st_tripped;
        end else if (tmo_dectrip) begin
          next_state = st_decel_trip;
        end else if (tmo_coast) begin
          next_state = st_coast;
        end else if (tmo_decel && state != st_coast) begin
          next_state = st_decel;
        end else if (state != st_normal && !drive_running) begin
          next_state = st_normal;
        end
      end
      default: next_state = st_normal;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) state <= st_normal;
    else state <= next_state;
  end

  // requests decoded from the state flop
  assign trip_req = (state == st_tripped);
  assign decel_stop_req = (state == st_decel) || (state == st_decel_trip);
  assign coast_stop_req = (state == st_coast);

  // ==========================================================
  // sticky flags and fault count; the set wins over the clear
  wire [7:0] next_fault_count =
    (fault_count == 8'hff) ? fault_count : fault_count + 8'h01;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link_seen <= 1'b0;
      tmo_seen <= 1'b0;
      fault_count <= 8'h00;
    end else begin
      link_seen <= link_fault || (link_seen && !clr_flag);
      tmo_seen <= tmo || (tmo_seen && !clr_flag);
      if (link_fault) fault_count <= next_fault_count;
      else if (clr_flag) fault_count <= 8'h00;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence seq_dt_arm;
    tmo_dectrip && !trip_evt && state != st_tripped &&
    state != st_decel_trip;
  endsequence

  sequence seq_dt_stopped;
    state == st_decel_trip && !drive_running;
  endsequence

  chk_fault_trip: assert property (
    fault_trip |=> trip_req)
    else $error("link fault did not trip");
  chk_fault_run: assert property (
    link_fault && !fault_trip && !tmo && state == st_normal
    |=> !trip_req)
    else $error("continued operation tripped");
  chk_tmo_trip: assert property (
    tmo_trip |=> trip_req)
    else $error("timeout action trip missing");
  chk_dectrip_seq: assert property (
    seq_dt_arm |=> decel_stop_req)
    else $error("decel before trip missing");
  chk_dectrip_end: assert property (
    seq_dt_stopped |=> trip_req)
    else $error("no trip after decel stop");
  chk_tmo_coast: assert property (
    tmo_coast && !trip_evt && state == st_normal
    |=> coast_stop_req ##1 (coast_stop_req || trip_req || !$past(drive_running)))
    else $error("coast stop missing");
  chk_station_max: assert property (
    station_address <= `OCS_MAX_STATION)
    else $error("station address out of range");
  chk_slot_write: assert property (
    wr_ok && w_hit |=> flex_wr[$past(w_idx)] == $past(pwdata[15:0]))
    else $error("write slot not stored");
  chk_slot_read: assert property (
    setup && !pwrite && r_hit
    |=> prdata == 32'(flex_rd[$past(r_idx)]))
    else $error("read slot read-back wrong");
  chk_mode_inert: assert property (
    wr_ok && (is_clrmode || is_mapsel) && state == st_normal &&
    !link_fault && !tmo |=> state == st_normal)
    else $error("mode setting changed behaviour");
  chk_trip_hold: assert property (
    trip_req && !clr_trip |=> trip_req)
    else $error("trip released without clear");
  chk_link_flag: assert property (
    link_fault |=> link_seen)
    else $error("link fault not flagged");
  chk_tmo_ignore: assert property (
    tmo && timeout_action == `OCS_ACT_IGNORE && state == st_normal && !link_fault
    |=> state == st_normal)
    else $error("ignored timeout changed state");
  chk_stop_release: assert property (
    (decel_stop_req || coast_stop_req) && !drive_running && !trip_evt && !tmo &&
    state != st_decel_trip |=> !decel_stop_req && !coast_stop_req)
    else $error("stop request outlived the run");

endmodule

// *** src/ocs_wdog.sv ***
// ocs_wdog.sv: host traffic watchdog on a 0.01 s time base
// assumes restart and enable synchronous to clk_sys
`include "ocs_cfg.svh"

module ocs_wdog
  import ocs_pkg::*;
#(
  parameter int TICK_CYCLES = `OCS_TICK_CYCLES,
  parameter int PERIOD_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic enable,
  input wire logic restart,
  input wire logic [PERIOD_W-1:0] period,
  // result
  output logic timeout,
  output logic [PERIOD_W-1:0] elapsed
);

  localparam int PW = $clog2(TICK_CYCLES + 1);

  generate
    if (TICK_CYCLES < 1 || PERIOD_W < 2) begin : g_bad
      $error("ocs_wdog: parameters out of range");
    end
  endgenerate

  logic [PW-1:0] pre;
  logic fired;

  // tick every 0.01 s; zero period means watchdog off
  wire tick = (pre == PW'(TICK_CYCLES - 1));
  wire hold = rst || restart || !enable || (period == '0);
  wire hit = tick && !fired && (elapsed == period - 1'b1);

  // fire once, then wait for fresh traffic or a stop
  always_ff @(posedge clk_sys) begin
    if (hold) begin
      pre <= '0;
      elapsed <= '0;
      fired <= 1'b0;
      timeout <= 1'b0;
    end else begin
      pre <= tick ? '0 : pre + 1'b1;
      if (tick && !fired) elapsed <= elapsed + 1'b1;
      fired <= fired || hit;
      timeout <= hit;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_restart_clear: assert property (
    restart |=> elapsed == '0 && !timeout)
    else $error("watchdog not cleared by traffic");
  chk_idle_hold: assert property (
    !enable |=> elapsed == '0)
    else $error("watchdog counts while idle");
  chk_fire_count: assert property (
    timeout |-> elapsed == $past(period))
    else $error("timeout at wrong count");
  chk_fire_once: assert property (
    timeout |=> !timeout)
    else $error("timeout longer than one cycle");

endmodule
